// >>> hw/pps_discipline_loop.sv
// Notes on behaviour
// - Reference comes from one of two selectable inputs.
// - Present flag set while selected reference pulses.
// - Step delta is difference of last two steering values.
// - Latest phase meter result is readable.
// - Enabled loop corrects once per second.
// - Selectable time constant sets loop settling.
// - Initial error is a running average over tau.
// - Reference loss holds steering; return resumes loop.
// - Large phase on return jams; single outliers ignored.
// - Lock cleared at start and without reference.
// - Lock set after two time constants inside threshold.
// - Settings are volatile unless stored explicitly.
// - Jam at loop start and on large phase.
// - Jam aligns phase only, frequency untouched.
// - Start jam always; later jams use bound.
// - Measure-only mode reports phase, never steers.
// - Reported phase ignores time constant.
// - Delay compensation limited to half second.
// - Compensation shifts loop zero, not reported phase.
// - Quantisation offset applies to next measurement only.
// - Seconds counter counts output pulse rising edges.
`default_nettype none

module pps_discipline_loop #(
   parameter int unsigned SEC_CYCLES = pps_pkg::SEC_CYC,
   parameter int unsigned REF_TO_CYCLES = pps_pkg::REF_TO_CYC
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Register port.
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [31:0] rdata_o,
   // Reference inputs and pulse output.
   input wire logic ref_a_i,
   input wire logic ref_b_i,
   output logic pps_o,
   // Request to save settings to non-volatile storage.
   output logic store_req_o
);
   import pps_pkg::*;

   // Loop modes.
   typedef enum logic [2:0] {M_IDLE, M_JAM_WAIT, M_JAM_ALIGN, M_TRACK, M_HOLD} loop_mode_t;

   // All state of the block.
   typedef struct packed {
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic ref_prev;
      logic loop_enable;
      logic measure_only_enable;
      logic ref_input_select;
      logic tau_sel;
      logic [3:0] loop_time_const_a;
      logic [3:0] loop_time_const_b;
      logic [31:0] phase_jump_bound;
      logic [31:0] lock_threshold;
      logic signed [31:0] input_delay_comp;
      logic signed [31:0] quantisation_offset;
      logic signed [31:0] freq_steer_value;
      logic signed [31:0] recent_step_delta;
      logic signed [31:0] phase;
      logic [31:0] seconds_count;
      logic [31:0] cnt;
      logic [31:0] period;
      logic [15:0] frac;
      logic signed [31:0] adj;
      logic adj_pend;
      logic [31:0] to_cnt;
      logic ref_present_flag;
      loop_mode_t mode;
      logic signed [31:0] avg;
      logic outlier;
      logic [31:0] lock_cnt;
      logic loop_lock_flag;
      logic pps;
      logic store;
      logic [31:0] rdata;
   } loop_state_t;

   loop_state_t s_q;
   loop_state_t s_d;

   // Phase meter link.
   pps_meter_if pm ();

   logic ref_sel_w;
   logic tick_w;

   if (REF_TO_CYCLES <= SEC_CYCLES) begin : g_bad_to
      $error("REF_TO_CYCLES must exceed SEC_CYCLES");
   end

   // Selected, synchronised reference and the end of the current output second.
   assign ref_sel_w = s_q.ref_input_select ? s_q.sync2[1] : s_q.sync2[0];
   assign pm.ref_edge = ref_sel_w & ~s_q.ref_prev;
   assign tick_w = (s_q.cnt == s_q.period - 32'h0000_0001);
   assign pm.out_tick = tick_w;

   pps_phase_meter #(
      .SEC_CYCLES(SEC_CYCLES)
   ) u_meter (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .pm(pm.meter)
   );

   // Next-state logic for the whole block.
   always_comb begin
      logic [3:0] tau;
      logic signed [31:0] ph_ns;
      logic signed [31:0] err_ns;
      logic signed [31:0] err_cyc;
      logic [31:0] abs_err;
      logic over;
      logic do_jam;
      logic do_upd;
      logic signed [31:0] avg_n;
      logic signed [31:0] nsteer;
      logic [16:0] fsum;
      logic signed [31:0] per;
      logic signed [31:0] wd;
      tau = s_q.tau_sel ? s_q.loop_time_const_b : s_q.loop_time_const_a;
      // Raw measurement plus one-shot quantisation offset, no tau involved.
      ph_ns = pm.meas_cyc * CLK_NS + s_q.quantisation_offset / PS_PER_NS;
      // Loop error measured from the compensated zero point.
      err_ns = ph_ns + s_q.input_delay_comp;
      err_cyc = err_ns / CLK_NS;
      abs_err = err_ns < 0 ? $unsigned(-err_ns) : $unsigned(err_ns);
      over = abs_err > s_q.phase_jump_bound;
      do_jam = 1'b0;
      do_upd = 1'b0;
      avg_n = s_q.avg + ((err_cyc - s_q.avg) >>> tau);
      fsum = {1'b0, s_q.frac} + {1'b0, s_q.freq_steer_value[15:0]};
      per = $signed(SEC_CYCLES) - (s_q.freq_steer_value >>> STEER_FRAC)
            - $signed({31'h0000_0000, fsum[16]});
      wd = $signed(wdata_i);
      nsteer = s_q.freq_steer_value;
      s_d = s_q;
      s_d.store = 1'b0;
      // Two-stage synchronisers for both reference pins.
      s_d.sync1 = {ref_b_i, ref_a_i};
      s_d.sync2 = s_q.sync1;
      s_d.ref_prev = ref_sel_w;

      // Presence watchdog: an edge sets the flag, a long silence clears it.
      if (pm.ref_edge) begin
         s_d.to_cnt = 32'h0000_0000;
         s_d.ref_present_flag = 1'b1;
      end else if (s_q.to_cnt >= REF_TO_CYCLES - 1) begin
         s_d.ref_present_flag = 1'b0;
      end else begin
         s_d.to_cnt = s_q.to_cnt + 32'h0000_0001;
      end

      // Output second: period steered by the frequency value plus any phase step.
      if (tick_w) begin
         s_d.cnt = 32'h0000_0000;
         s_d.frac = fsum[15:0];
         if (s_q.adj_pend) begin
            per = per + s_q.adj;
         end
         s_d.adj_pend = 1'b0;
         s_d.period = per < $signed(2 * PULSE_CYC) ? 2 * PULSE_CYC : $unsigned(per);
         s_d.seconds_count = s_q.seconds_count + 32'h0000_0001;
      end else begin
         s_d.cnt = s_q.cnt + 32'h0000_0001;
      end
      // The pulse starts only at a tick, so no stray edge follows reset.
      if (tick_w) begin
         s_d.pps = 1'b1;
      end else if (s_d.cnt >= PULSE_CYC) begin
         s_d.pps = 1'b0;
      end

      // Every measurement is reported, whatever the mode.
      if (pm.meas_valid) begin
         s_d.phase = ph_ns;
         s_d.quantisation_offset = 32'h0000_0000;
      end

      // Loop sequencing; measure-only mode keeps the loop idle.
      if (!s_q.loop_enable || s_q.measure_only_enable) begin
         s_d.mode = M_IDLE;
         s_d.loop_lock_flag = 1'b0;
      end else begin
         unique case (s_q.mode)
            M_IDLE: begin
               // A fresh start always begins with a jam.
               s_d.mode = M_JAM_WAIT;
               s_d.avg = 32'h0000_0000;
               s_d.lock_cnt = 32'h0000_0000;
               s_d.loop_lock_flag = 1'b0;
            end
            M_JAM_WAIT: begin
               if (pm.meas_valid) begin
                  do_jam = 1'b1;
               end
            end
            M_JAM_ALIGN: begin
               // Aligned once the stepped second has fully run out.
               if (tick_w && !s_q.adj_pend) begin
                  s_d.mode = M_TRACK;
               end
            end
            M_TRACK: begin
               if (!s_q.ref_present_flag) begin
                  s_d.mode = M_HOLD;
               end else if (pm.meas_valid && over) begin
                  // A second outlier in a row is a real jump.
                  s_d.outlier = 1'b1;
                  do_jam = s_q.outlier;
               end else if (pm.meas_valid) begin
                  s_d.outlier = 1'b0;
                  do_upd = 1'b1;
               end
            end
            M_HOLD: begin
               // Steering stays frozen until the reference returns.
               if (pm.meas_valid) begin
                  s_d.mode = M_TRACK;
                  do_jam = over;
                  do_upd = !over;
               end
            end
         endcase
      end

      // Jam: one phase step equal to the error, frequency left alone.
      if (do_jam) begin
         s_d.adj = err_cyc;
         s_d.adj_pend = 1'b1;
         s_d.mode = M_JAM_ALIGN;
         s_d.avg = 32'h0000_0000;
         s_d.outlier = 1'b0;
         s_d.lock_cnt = 32'h0000_0000;
         s_d.loop_lock_flag = 1'b0;
      end

      // Once-a-second correction: phase share now, frequency from the average.
      if (do_upd) begin
         s_d.avg = avg_n;
         // A positive error means the output runs early: lengthen the second, steer down.
         s_d.adj = err_cyc >>> tau;
         s_d.adj_pend = 1'b1;
         nsteer = s_q.freq_steer_value
                  - ((avg_n <<< STEER_FRAC) >>> ({1'b0, tau} + {1'b0, tau} + 5'h01));
         s_d.freq_steer_value = nsteer;
         s_d.recent_step_delta = nsteer - s_q.freq_steer_value;
         if (abs_err < s_q.lock_threshold) begin
            s_d.lock_cnt = s_q.lock_cnt + 32'h0000_0001;
            if (s_q.lock_cnt + 32'h0000_0001 >= (32'h0000_0002 << tau)) begin
               s_d.loop_lock_flag = 1'b1;
            end
         end else begin
            s_d.lock_cnt = 32'h0000_0000;
            s_d.loop_lock_flag = 1'b0;
         end
      end else begin
         nsteer = s_q.freq_steer_value;
      end

      // No reference means no lock.
      if (!s_q.ref_present_flag) begin
         s_d.loop_lock_flag = 1'b0;
      end

      // Register writes override hardware updates in the same cycle.
      if (we_i) begin
         unique case (addr_i)
            OFS_CTRL: begin
               s_d.loop_enable = wdata_i[CTRL_EN];
               s_d.measure_only_enable = wdata_i[CTRL_MEAS];
               s_d.ref_input_select = wdata_i[CTRL_SEL];
               s_d.tau_sel = wdata_i[CTRL_TAU];
               s_d.store = wdata_i[CTRL_STORE];
            end
            OFS_STEER: begin
               s_d.freq_steer_value = wd;
               s_d.recent_step_delta = wd - s_q.freq_steer_value;
            end
            OFS_TAU_A: s_d.loop_time_const_a = wdata_i[3:0] > TAU_MAX ? TAU_MAX : wdata_i[3:0];
            OFS_TAU_B: s_d.loop_time_const_b = wdata_i[3:0] > TAU_MAX ? TAU_MAX : wdata_i[3:0];
            OFS_BOUND: s_d.phase_jump_bound = wdata_i;
            OFS_THRESH: s_d.lock_threshold = wdata_i;
            OFS_COMP: begin
               // Clamp to half a second either way.
               if (wd > COMP_MAX_NS) begin
                  s_d.input_delay_comp = COMP_MAX_NS;
               end else if (wd < -COMP_MAX_NS) begin
                  s_d.input_delay_comp = -COMP_MAX_NS;
               end else begin
                  s_d.input_delay_comp = wd;
               end
            end
            OFS_QERR: s_d.quantisation_offset = wd;
            OFS_SECS: s_d.seconds_count = wdata_i;
            default: begin
            end
         endcase
      end

      // Read data stand for exactly one cycle; unmapped offsets read zero.
      s_d.rdata = 32'h0000_0000;
      if (re_i) begin
         unique case (addr_i)
            OFS_CTRL: begin
               s_d.rdata[CTRL_EN] = s_q.loop_enable;
               s_d.rdata[CTRL_MEAS] = s_q.measure_only_enable;
               s_d.rdata[CTRL_SEL] = s_q.ref_input_select;
               s_d.rdata[CTRL_TAU] = s_q.tau_sel;
            end
            OFS_STATUS: begin
               s_d.rdata[STAT_PRESENT] = s_q.ref_present_flag;
               s_d.rdata[STAT_LOCK] = s_q.loop_lock_flag;
               s_d.rdata[STAT_ALIGN] = s_q.mode inside {M_JAM_WAIT, M_JAM_ALIGN};
               s_d.rdata[STAT_HOLD] = s_q.mode == M_HOLD;
            end
            OFS_STEER: s_d.rdata = s_q.freq_steer_value;
            OFS_DELTA: s_d.rdata = s_q.recent_step_delta;
            OFS_PHASE: s_d.rdata = s_q.phase;
            OFS_TAU_A: s_d.rdata[3:0] = s_q.loop_time_const_a;
            OFS_TAU_B: s_d.rdata[3:0] = s_q.loop_time_const_b;
            OFS_BOUND: s_d.rdata = s_q.phase_jump_bound;
            OFS_THRESH: s_d.rdata = s_q.lock_threshold;
            OFS_COMP: s_d.rdata = s_q.input_delay_comp;
            OFS_QERR: s_d.rdata = s_q.quantisation_offset;
            OFS_SECS: s_d.rdata = s_q.seconds_count;
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   // State register; every setting returns to its default on reset.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q <= '0;
         s_q.loop_time_const_a <= TAU_RST;
         s_q.loop_time_const_b <= TAU_RST;
         s_q.phase_jump_bound <= BOUND_RST;
         s_q.lock_threshold <= THRESH_RST;
         s_q.period <= SEC_CYCLES;
         s_q.mode <= M_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_o = s_q.rdata;
   assign pps_o = s_q.pps;
   assign store_req_o = s_q.store;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   // Silence past the window clears the present flag.
   chk_present_timeout: assert property (s_q.to_cnt >= REF_TO_CYCLES - 1 && !pm.ref_edge
      |=> !s_q.ref_present_flag)
      else $error("present flag survived timeout");
   // A selected edge raises the present flag next cycle.
   chk_present_edge: assert property (pm.ref_edge |=> s_q.ref_present_flag)
      else $error("edge did not set present flag");
   // Lock never stands without a reference.
   chk_lock_noref: assert property (!s_q.ref_present_flag |=> !s_q.loop_lock_flag)
      else $error("lock held without reference");
   // Starting the loop enters a jam with lock cleared.
   chk_start_jam: assert property (s_q.mode == M_IDLE && s_q.loop_enable
      && !s_q.measure_only_enable && !we_i |=> s_q.mode == M_JAM_WAIT
      ##0 !s_q.loop_lock_flag)
      else $error("loop start skipped the jam");
   // The step delta tracks every steering change.
   chk_step_delta: assert property (s_q.freq_steer_value != $past(s_q.freq_steer_value)
      |-> s_q.recent_step_delta == s_q.freq_steer_value - $past(s_q.freq_steer_value))
      else $error("step delta wrong");
   // The quantisation offset is spent by one measurement.
   chk_qerr_once: assert property (pm.meas_valid && !(we_i && addr_i == OFS_QERR)
      |=> s_q.quantisation_offset == 32'h0000_0000
      ##1 (s_q.phase == $past(s_q.phase) || $past(pm.meas_valid)))
      else $error("quantisation offset reused");
   // Measure-only mode leaves steering alone.
   chk_measure_still: assert property (s_q.measure_only_enable && !we_i
      |=> $stable(s_q.freq_steer_value))
      else $error("steered in measure-only mode");
   // Holdover keeps the last steering value.
   chk_hold_keep: assert property (s_q.mode == M_HOLD && !pm.meas_valid && !we_i
      |=> $stable(s_q.freq_steer_value))
      else $error("steering moved in holdover");
   // Seconds advance with each output pulse.
   chk_secs_inc: assert property (tick_w && !(we_i && addr_i == OFS_SECS)
      |=> s_q.seconds_count == $past(s_q.seconds_count) + 32'h0000_0001 ##0 pps_o)
      else $error("seconds did not follow pulse");
   // Lock rises only after a full two time constants.
   chk_lock_time: assert property ($rose(s_q.loop_lock_flag)
      |-> $past(s_q.lock_cnt) + 32'h0000_0001 >= (32'h0000_0002 << (s_q.tau_sel
      ? s_q.loop_time_const_b : s_q.loop_time_const_a)))
      else $error("lock rose too early");

   cov_lock: cover property ($rose(s_q.loop_lock_flag));
   cov_jam: cover property (s_q.mode == M_TRACK ##1 s_q.mode == M_JAM_ALIGN);
   cov_hold: cover property (s_q.mode == M_HOLD ##1 s_q.mode == M_TRACK);
   cov_outlier: cover property ($rose(s_q.outlier) ##1 s_q.mode == M_TRACK);
endmodule : pps_discipline_loop

`default_nettype wire

// >>> hw/pps_meter_if.sv
`default_nettype none

// Carries output ticks and reference edges to the phase meter and its result back.
interface pps_meter_if;
   logic out_tick;
   logic ref_edge;
   logic meas_valid;
   logic signed [31:0] meas_cyc;
   modport meter (input out_tick, input ref_edge, output meas_valid, output meas_cyc);
   modport core (output out_tick, output ref_edge, input meas_valid, input meas_cyc);
endinterface : pps_meter_if

`default_nettype wire

// >>> hw/pps_phase_meter.sv
`default_nettype none

module pps_phase_meter #(
   parameter int unsigned SEC_CYCLES = pps_pkg::SEC_CYC
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Link to the loop core.
   pps_meter_if.meter pm
);
   import pps_pkg::*;

   // Counter since the last output tick, and the result register.
   typedef struct packed {
      logic [31:0] cnt;
      logic seen;
      logic valid;
      logic signed [31:0] res;
   } meter_state_t;

   meter_state_t s_q;
   meter_state_t s_d;

   if (SEC_CYCLES < 32'h0000_0004 || SEC_CYCLES > 32'h7FFF_FFFF) begin : g_bad_sec
      $error("SEC_CYCLES out of range");
   end

   // Time the reference edge against the output tick; fold to plus or minus half a second.
   always_comb begin
      logic [31:0] now;
      now = pm.out_tick ? 32'h0000_0000 : s_q.cnt;
      s_d = s_q;
      s_d.valid = 1'b0;
      if (pm.out_tick) begin
         s_d.cnt = 32'h0000_0001;
         s_d.seen = 1'b1;
      end else if (s_q.cnt != 32'hFFFF_FFFF) begin
         s_d.cnt = s_q.cnt + 32'h0000_0001;
      end
      // A measurement needs one output tick seen first.
      if (pm.ref_edge && (s_q.seen || pm.out_tick)) begin
         s_d.valid = 1'b1;
         if (now < (SEC_CYCLES / 2)) begin
            s_d.res = $signed(now);
         end else begin
            s_d.res = $signed(now - SEC_CYCLES);
         end
      end
   end

   // State register.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pm.meas_valid = s_q.valid;
   assign pm.meas_cyc = s_q.res;

   // A result never reaches beyond half a second either way.
   chk_meter_fold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      pm.meas_valid |-> (pm.meas_cyc <= $signed(SEC_CYCLES / 2)
                         && pm.meas_cyc >= -$signed(SEC_CYCLES / 2)))
      else $error("phase result out of range");
endmodule : pps_phase_meter

`default_nettype wire

// >>> hw/pps_pkg.sv
`default_nettype none

package pps_pkg;
   // Clock and time base.
   localparam int CLK_NS = 10;
   localparam int SEC_NS = 1_000_000_000;
   localparam int unsigned SEC_CYC = SEC_NS / CLK_NS;
   // A reference is lost when no edge comes within this window.
   localparam int REF_TO_NS = 1_100_000_000;
   localparam int unsigned REF_TO_CYC = REF_TO_NS / CLK_NS;
   // Width of the high phase of the output pulse.
   localparam int PULSE_NS = 100;
   localparam int unsigned PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   // Unit conversion for the quantisation offset.
   localparam int PS_PER_NS = 1000;
   // Largest delay compensation magnitude, half a second in ns.
   localparam int COMP_MAX_NS = 500_000_000;
   // Steering value carries this many fraction bits of a cycle per second.
   localparam int STEER_FRAC = 16;
   // Largest time constant exponent that the loop accepts.
   localparam logic [3:0] TAU_MAX = 4'hF;

   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_STEER = 8'h08;
   localparam logic [7:0] OFS_DELTA = 8'h0C;
   localparam logic [7:0] OFS_PHASE = 8'h10;
   localparam logic [7:0] OFS_TAU_A = 8'h14;
   localparam logic [7:0] OFS_TAU_B = 8'h18;
   localparam logic [7:0] OFS_BOUND = 8'h1C;
   localparam logic [7:0] OFS_THRESH = 8'h20;
   localparam logic [7:0] OFS_COMP = 8'h24;
   localparam logic [7:0] OFS_QERR = 8'h28;
   localparam logic [7:0] OFS_SECS = 8'h2C;

   // Control register bit positions.
   localparam int CTRL_EN = 0;
   localparam int CTRL_MEAS = 1;
   localparam int CTRL_SEL = 2;
   localparam int CTRL_TAU = 3;
   localparam int CTRL_STORE = 4;
   // Status register bit positions.
   localparam int STAT_PRESENT = 0;
   localparam int STAT_LOCK = 1;
   localparam int STAT_ALIGN = 2;
   localparam int STAT_HOLD = 3;

   // Reset values of the settings.
   localparam logic [3:0] TAU_RST = 4'h4;
   localparam logic [31:0] BOUND_RST = 32'h0000_03E8;
   localparam logic [31:0] THRESH_RST = 32'h0000_0064;
endpackage : pps_pkg

`default_nettype wire

// >>> test/pps_discipline_loop_tb.sv
`default_nettype none

module pps_discipline_loop_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pps_pkg::*;
   localparam int SEC = 1000; // Shortened second in cycles.
   localparam logic [7:0] RA[8] = '{OFS_CTRL, OFS_STATUS, OFS_STEER, OFS_TAU_A, OFS_TAU_B,
      OFS_BOUND, OFS_THRESH, 8'h30};
   localparam logic [31:0] RV[8] = '{0, 0, 0, 32'(TAU_RST), 32'(TAU_RST), BOUND_RST,
      THRESH_RST, 0};
   logic clk_i = 0, arst_n_i = 0, we_i = 0, re_i = 0, rd_pend = 0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0000_0000, rdata_o, last_rd, w, s;
   logic ref_a, ref_b, en_a = 0, en_b = 0, pps_o, store_req;
   logic [15:0] dly = 16'h0064; // Reference delay in cycles.
   int n_mismatch = 0, n_tests = 0, p, d, n_store = 0;
   typedef struct {logic [31:0] v; logic [31:0] m;} exp_t;
   exp_t q[$], e; // Expected read data in issue order; a zero mask only captures.

   pps_ref_model i_pps_ref_model (.clk_i(clk_i), .period_i(16'(SEC)), .delay_i(dly),
      .en_a_i(en_a), .en_b_i(en_b), .ref_a_o(ref_a), .ref_b_o(ref_b));
   pps_discipline_loop #(.SEC_CYCLES(SEC), .REF_TO_CYCLES(1100)) i_pps_discipline_loop (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
      .re_i(re_i), .rdata_o(rdata_o), .ref_a_i(ref_a), .ref_b_i(ref_b), .pps_o(pps_o),
      .store_req_o(store_req));

   always #5 clk_i = ~clk_i;
   // Counts store request pulses, sampled mid-cycle where they are settled.
   always @(negedge clk_i) if (store_req) n_store++;
   // Read data stand in the cycle after the strobe, so they are sampled mid-cycle.
   always @(posedge clk_i) rd_pend <= re_i;
   always @(negedge clk_i) begin
      if (rd_pend) begin
         e = q.pop_front();
         last_rd = rdata_o;
         if (e.m != 0) begin
            n_tests++;
            if ((rdata_o & e.m) !== e.v) begin
               n_mismatch++;
               $display("mismatch at %0t: read %h expected %h", $time, rdata_o, e.v);
            end
         end
      end
   end

   // One write cycle; a spare edge keeps the strobe from being set twice in one step.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      addr_i <= a;
      wdata_i <= v;
      we_i <= 1'b1;
      @(posedge clk_i);
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // One read cycle; returns once the data have been taken into last_rd.
   task automatic rd(input logic [7:0] a, input logic [31:0] v = 0, input logic [31:0] m = 0);
      q.push_back('{v & m, m});
      addr_i <= a;
      re_i <= 1'b1;
      @(posedge clk_i);
      re_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic chk(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   // Polls a field until it shows the value, for a bounded number of tries.
   task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      for (int i = 0; i < 60; i++) begin
         rd(a);
         if ((last_rd & m) === v) break;
         repeat (400) @(posedge clk_i);
      end
      chk((last_rd & m) === v, "field never reached its value");
   endtask
   task automatic secs(input int n);
      repeat (n * SEC) @(posedge clk_i);
   endtask
   task automatic test_done();
      $display("counts: %0d mismatches in %0d comparisons", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog: the sequence needs about 30 seconds of shortened time.
   initial begin
      repeat (90 * SEC) @(posedge clk_i);
      n_mismatch++;
      test_done();
   end

   initial begin
      void'($urandom(61));
      repeat (8) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      wr(8'h30, 32'hFFFF_FFFF);
      wr(OFS_STATUS, 32'hFFFF_FFFF);
      foreach (RA[i]) rd(RA[i], RV[i], 32'hFFFF_FFFF);
      // Seconds count follows the output pulse from a written start value.
      w = $urandom;
      wr(OFS_SECS, w);
      repeat (3) @(posedge pps_o);
      rd(OFS_SECS, w + 3, 32'hFFFF_FFFF);
      // Measure-only mode on input a.
      en_a <= 1'b1;
      wr(OFS_CTRL, 32'h0000_0012);
      chk(n_store == 1, "store request not pulsed once");
      secs(3);
      rd(OFS_STATUS, 1, 1);
      rd(OFS_PHASE);
      p = $signed(last_rd);
      d = 1 + $urandom % 200;
      dly <= dly + 16'(d);
      secs(3);
      rd(OFS_PHASE, p + d * 10, 32'hFFFF_FFFF);
      rd(OFS_STEER, 0, 32'hFFFF_FFFF);
      p = p + d * 10;
      wr(OFS_TAU_B, 32'h0000_0009);
      wr(OFS_CTRL, 32'h0000_000A);
      wr(OFS_COMP, 32'h7FFF_FFFF);
      rd(OFS_COMP, 32'(COMP_MAX_NS), 32'hFFFF_FFFF);
      wr(OFS_COMP, 32'h8000_0000);
      rd(OFS_COMP, 32'(-COMP_MAX_NS), 32'hFFFF_FFFF);
      secs(2);
      rd(OFS_PHASE, p, 32'hFFFF_FFFF);
      wr(OFS_COMP, 32'h0000_0000);
      wr(OFS_QERR, 32'h0000_1388);
      poll(OFS_QERR, 32'hFFFF_FFFF, 0);
      rd(OFS_PHASE, p + 5, 32'hFFFF_FFFF);
      secs(1);
      rd(OFS_PHASE, p, 32'hFFFF_FFFF);
      // Input b only: selecting a loses the reference, selecting b finds it.
      en_a <= 1'b0;
      en_b <= 1'b1;
      secs(2);
      rd(OFS_STATUS, 0, 1);
      wr(OFS_CTRL, 32'h0000_0006);
      secs(2);
      rd(OFS_STATUS, 1, 1);
      // Loop start on input a with a one-second time constant.
      en_a <= 1'b1;
      en_b <= 1'b0;
      wr(OFS_TAU_A, 32'h0000_0000);
      wr(OFS_CTRL, 32'h0000_0001);
      rd(OFS_STATUS, 4, 6);
      poll(OFS_STATUS, 2, 2);
      rd(OFS_PHASE);
      chk($signed(last_rd) < 100 && $signed(last_rd) > -100, "phase not aligned");
      w = 1 + $urandom % 1000;
      wr(OFS_STEER, w);
      secs(1);
      rd(OFS_STEER);
      s = last_rd;
      rd(OFS_DELTA, s - w, 32'hFFFF_FFFF);
      // Reference loss holds the steering; a far-off return jams and relocks.
      rd(OFS_STEER);
      s = last_rd;
      en_a <= 1'b0;
      secs(2);
      rd(OFS_STATUS, 8, 11);
      rd(OFS_STEER, s, 32'hFFFF_FFFF);
      dly <= dly + 16'h0096;
      en_a <= 1'b1;
      secs(2);
      rd(OFS_STATUS, 1, 9);
      poll(OFS_STATUS, 2, 2);
      test_done();
   end
endmodule // pps_discipline_loop_tb

`default_nettype wire

// >>> test/pps_ref_model.sv
`default_nettype none

// Free-running reference source with its own time base and two pulse lines.
module pps_ref_model (
   // Clock.
   input wire logic clk_i,
   // Period and delay in cycles, and line enables.
   input wire logic [15:0] period_i,
   input wire logic [15:0] delay_i,
   input wire logic en_a_i,
   input wire logic en_b_i,
   // Pulse lines, pulled low when idle.
   output logic ref_a_o,
   output logic ref_b_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_q = 16'h0000; // Position in the reference second.
   logic mark; // High for ten cycles at the delayed on-time point.
   // Time is kept apart from the output, so a loop cannot pull the reference along.
   always @(posedge clk_i) begin
      cnt_q <= (cnt_q + 16'h0001 >= period_i) ? 16'h0000 : cnt_q + 16'h0001;
   end
   assign mark = ((cnt_q + period_i - delay_i) % period_i) < 16'h000A;
   assign ref_a_o = en_a_i & mark;
   assign ref_b_o = en_b_i & mark;
endmodule // pps_ref_model

`default_nettype wire
